/* File: verilog/core_regs_pkg.sv */
// Constants shared by the core register set
package core_regs_pkg;
    localparam int SEL_W = 5;
    // Operand selects; also APB word index
    localparam logic [4:0] SEL_DATA0 = 5'h00;
    localparam logic [4:0] SEL_DATA3 = 5'h03;
    localparam logic [4:0] SEL_FB    = 5'h06;
    localparam logic [4:0] SEL_D0_LO = 5'h08;
    localparam logic [4:0] SEL_D1_HI = 5'h0B;
    localparam logic [4:0] SEL_PAIR_LO = 5'h0C;
    localparam logic [4:0] SEL_PAIR_HI = 5'h0D;
    localparam logic [4:0] SEL_A_PAIR  = 5'h0E;
    localparam logic [4:0] SEL_SB    = 5'h0F;
    localparam logic [4:0] SEL_VECTOR_TABLE_BASE  = 5'h10;
    localparam logic [4:0] SEL_PC    = 5'h11;
    localparam logic [4:0] SEL_USP   = 5'h12;
    localparam logic [4:0] SEL_ISP   = 5'h13;
    localparam logic [4:0] SEL_SP    = 5'h14;
    localparam logic [4:0] SEL_FLG   = 5'h15;
    localparam logic [4:0] SEL_LAST  = 5'h15;
    localparam int BANK_ENTRIES = 7;
    // Flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_U = 7;
    localparam int FLG_W = 11;
    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_PC   = 20'h00000;
    localparam logic [19:0] RST_VECTOR_TABLE_BASE = 20'h00000;
    localparam logic [10:0] RST_FLG  = 11'h000;
    // ALU operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    // Address map
    localparam logic [19:0] SFR0_END  = 20'h002FF;
    localparam logic [19:0] SFR1_BASE = 20'h02C00;
    localparam logic [19:0] SFR1_END  = 20'h02FFF;
    localparam logic [19:0] RAM_BASE  = 20'h00400;
    localparam logic [19:0] DFL_BASE  = 20'h03000;
    localparam logic [19:0] VEC_BASE  = 20'h0FFDC;
    localparam logic [19:0] VEC_END   = 20'h0FFFF;
    // Region codes
    localparam logic [2:0] RG_OTHER = 3'h0;
    localparam logic [2:0] RG_SFR   = 3'h1;
    localparam logic [2:0] RG_RAM   = 3'h2;
    localparam logic [2:0] RG_DFL   = 3'h3;
    localparam logic [2:0] RG_VEC   = 3'h4;
endpackage

/* File: verilog/core_regs.sv */
// Programmer-visible register set of the 16-bit core with APB view
// Summary of operation
// - Four 16-bit data registers for transfer, arithmetic and logic.
// - Data registers 0 and 1 split into independent upper and lower bytes.
// - Registers 2:0 and 3:1 pair as 32-bit values, 2 or 3 upper.
// - Two 16-bit address registers, usable as operands too.
// - Address registers pair into 32 bits, register one upper.
// - 16-bit frame base register.
// - 20-bit vector table base register.
// - 20-bit program counter holds next instruction address.
// - User and interrupt stack pointers, stack-select flag picks the active one.
// - 16-bit static base register.
// - 11-bit flag register with carry, debug, zero, sign, bank, overflow, stack.
// - Carry captures ALU carry, borrow or shifted-out bit.
// - Zero flag is 1 for a zero result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Bank flag 0 selects bank 0, 1 selects bank 1.
// - Overflow flag is 1 on overflow, else 0.
// - One-megabyte space over 20-bit addresses.
// - Fixed vector table sits at the top of the first 64 KB page.
// - Internal RAM starts at its base and grows upward.
// - Special function registers occupy two fixed ranges; holes are reserved.
// - Data flash starts at its base and grows upward.
`timescale 1ns/1ps
module core_regs
    import core_regs_pkg::*;
#(
    parameter int          APB_AW   = 8,
    parameter logic [19:0] RAM_END  = 20'h011FF,
    parameter logic [19:0] DFL_END  = 20'h037FF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              eu_wr_en,
    input  wire logic [SEL_W-1:0]  eu_wr_sel,
    input  wire logic [31:0]       eu_wr_data,
    input  wire logic [SEL_W-1:0]  eu_rd_sel,
    output logic      [31:0]       eu_rd_data,
    input  wire logic              alu_flag_en,
    input  wire logic [1:0]        alu_size,
    input  wire logic [31:0]       alu_result,
    input  wire logic              alu_carry,
    input  wire logic              alu_overflow,
    input  wire logic              pc_adv_en,
    input  wire logic [3:0]        pc_adv_len,
    input  wire logic [19:0]       mem_addr,
    output logic      [2:0]        mem_region,
    output logic      [19:0]       pc_out,
    output logic      [19:0]       vector_table_base_out,
    output logic      [FLG_W-1:0]  flags_out
);

    logic [15:0]      bank_ff [2][BANK_ENTRIES];
    logic [15:0]      static_base_ff;
    logic [19:0]      vector_table_base_ff;
    logic [19:0]      program_counter_ff;
    logic [15:0]      user_stack_pointer_ff;
    logic [15:0]      interrupt_stack_pointer_ff;
    logic [FLG_W-1:0] cpu_flags_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic [31:0]      eu_rd_data_ff;
    logic [2:0]       mem_region_ff;
    logic [15:0]      cur     [BANK_ENTRIES];
    logic [15:0]      wv      [BANK_ENTRIES];
    logic [BANK_ENTRIES-1:0] lo_we;
    logic [BANK_ENTRIES-1:0] hi_we;
    logic             bk;
    logic             sel_ok;
    logic             apb_wr;
    logic             wr_en;
    logic [SEL_W-1:0] wr_sel;
    logic [31:0]      wd;
    logic [31:0]      res_m;
    logic             res_neg;
    logic [FLG_W-1:0] nxt_flags;
    logic [19:0]      nxt_pc;

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign eu_rd_data = eu_rd_data_ff;
    assign mem_region = mem_region_ff;
    assign pc_out     = program_counter_ff;
    assign vector_table_base_out   = vector_table_base_ff;
    assign flags_out  = cpu_flags_ff;

    assign bk = cpu_flags_ff[FLG_B];
    assign sel_ok = (paddr[APB_AW-1:7] == '0) && (paddr[6:2] <= SEL_LAST)
                  && (paddr[6:2] != 5'h07);

    always_comb begin
        for (int i = 0; i < BANK_ENTRIES; i++) begin
            cur[i] = bank_ff[bk][i];
        end
    end

    function automatic logic [31:0] rd_val(input logic [SEL_W-1:0] s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (s <= SEL_FB && s != 5'h07) begin
            v = {16'h0000, cur[s[2:0]]};
        end else if (s >= SEL_D0_LO && s <= SEL_D1_HI) begin
            v = {24'h000000, s[0] ? cur[s[1]][15:8] : cur[s[1]][7:0]};
        end else begin
            case (s)
                SEL_PAIR_LO: v = {cur[2], cur[0]};
                SEL_PAIR_HI: v = {cur[3], cur[1]};
                SEL_A_PAIR:  v = {cur[5], cur[4]};
                SEL_SB:      v = {16'h0000, static_base_ff};
                SEL_VECTOR_TABLE_BASE:    v = {12'h000, vector_table_base_ff};
                SEL_PC:      v = {12'h000, program_counter_ff};
                SEL_USP:     v = {16'h0000, user_stack_pointer_ff};
                SEL_ISP:     v = {16'h0000, interrupt_stack_pointer_ff};
                SEL_SP:      v = {16'h0000, cpu_flags_ff[FLG_U] ?
                                 interrupt_stack_pointer_ff : user_stack_pointer_ff};
                SEL_FLG:     v = {21'h000000, cpu_flags_ff};
                default:     v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // APB takes priority; a same-cycle execution unit write is dropped
    assign apb_wr = psel & penable & pwrite & pready_ff & sel_ok;
    assign wr_en  = apb_wr | eu_wr_en;
    assign wr_sel = apb_wr ? paddr[6:2] : eu_wr_sel;
    assign wd     = apb_wr ? pwdata : eu_wr_data;

    always_comb begin
        lo_we = '0;
        hi_we = '0;
        for (int i = 0; i < BANK_ENTRIES; i++) begin
            wv[i] = wd[15:0];
        end
        if (wr_en) begin
            if (wr_sel <= SEL_FB && wr_sel != 5'h07) begin
                lo_we[wr_sel[2:0]] = 1'b1;
                hi_we[wr_sel[2:0]] = 1'b1;
            end else if (wr_sel >= SEL_D0_LO && wr_sel <= SEL_D1_HI) begin
                // Only the addressed half is enabled
                lo_we[wr_sel[1]] = ~wr_sel[0];
                hi_we[wr_sel[1]] = wr_sel[0];
                wv[wr_sel[1]] = {wd[7:0], wd[7:0]};
            end else if (wr_sel == SEL_PAIR_LO || wr_sel == SEL_PAIR_HI) begin
                lo_we[wr_sel[0]] = 1'b1;
                hi_we[wr_sel[0]] = 1'b1;
                lo_we[2 + 32'(wr_sel[0])] = 1'b1;
                hi_we[2 + 32'(wr_sel[0])] = 1'b1;
                wv[2] = wd[31:16];
                wv[3] = wd[31:16];
            end else if (wr_sel == SEL_A_PAIR) begin
                lo_we[5:4] = 2'h3;
                hi_we[5:4] = 2'h3;
                wv[5] = wd[31:16];
            end
        end
    end

    // Two banks of data, address and frame base registers
    for (genvar b = 0; b < 2; b++) begin : g_bank
        for (genvar e = 0; e < BANK_ENTRIES; e++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_ff[b][e] <= RST_WORD;
                end else if (bk == 1'(b)) begin
                    if (lo_we[e]) begin
                        bank_ff[b][e][7:0] <= wv[e][7:0];
                    end
                    if (hi_we[e]) begin
                        bank_ff[b][e][15:8] <= wv[e][15:8];
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            static_base_ff <= RST_WORD;
            vector_table_base_ff <= RST_VECTOR_TABLE_BASE;
        end else if (wr_en && wr_sel == SEL_SB) begin
            static_base_ff <= wd[15:0];
        end else if (wr_en && wr_sel == SEL_VECTOR_TABLE_BASE) begin
            vector_table_base_ff <= wd[19:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_stack_pointer_ff <= RST_WORD;
            interrupt_stack_pointer_ff <= RST_WORD;
        end else if (wr_en) begin
            if (wr_sel == SEL_USP || (wr_sel == SEL_SP && !cpu_flags_ff[FLG_U])) begin
                user_stack_pointer_ff <= wd[15:0];
            end
            if (wr_sel == SEL_ISP || (wr_sel == SEL_SP && cpu_flags_ff[FLG_U])) begin
                interrupt_stack_pointer_ff <= wd[15:0];
            end
        end
    end

    // Program counter: explicit load beats sequential advance
    assign nxt_pc = (wr_en && wr_sel == SEL_PC) ? wd[19:0] :
                    pc_adv_en ? program_counter_ff + 20'(pc_adv_len) :
                    program_counter_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_ff <= RST_PC;
        end else begin
            program_counter_ff <= nxt_pc;
        end
    end

    always_comb begin
        case (alu_size)
            SZ_BYTE: res_m = {24'h000000, alu_result[7:0]};
            SZ_WORD: res_m = {16'h0000, alu_result[15:0]};
            default: res_m = alu_result;
        endcase
        res_neg = (alu_size == SZ_BYTE) ? alu_result[7] :
                  (alu_size == SZ_WORD) ? alu_result[15] : alu_result[31];
    end

    // ALU status wins over a same-cycle software write of the flags
    always_comb begin
        nxt_flags = cpu_flags_ff;
        if (wr_en && wr_sel == SEL_FLG) begin
            nxt_flags = wd[FLG_W-1:0];
        end
        if (alu_flag_en) begin
            nxt_flags[FLG_C] = alu_carry;
            nxt_flags[FLG_Z] = (res_m == 32'h0000_0000);
            nxt_flags[FLG_S] = res_neg;
            nxt_flags[FLG_O] = alu_overflow;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_flags_ff <= RST_FLG;
        end else begin
            cpu_flags_ff <= nxt_flags;
        end
    end

    // Zero-wait APB: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~sel_ok;
            prdata_ff <= (sel_ok && !pwrite) ? rd_val(paddr[6:2]) : 32'h0000_0000;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eu_rd_data_ff <= 32'h0000_0000;
        end else begin
            eu_rd_data_ff <= rd_val(eu_rd_sel);
        end
    end

    // Region decode; reserved SPECIAL_FUNCTION_AREA holes are not resolved here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_region_ff <= RG_OTHER;
        end else if (mem_addr <= SFR0_END ||
                     (mem_addr >= SFR1_BASE && mem_addr <= SFR1_END)) begin
            mem_region_ff <= RG_SFR;
        end else if (mem_addr >= RAM_BASE && mem_addr <= RAM_END) begin
            mem_region_ff <= RG_RAM;
        end else if (mem_addr >= DFL_BASE && mem_addr <= DFL_END) begin
            mem_region_ff <= RG_DFL;
        end else if (mem_addr >= VEC_BASE && mem_addr <= VEC_END) begin
            mem_region_ff <= RG_VEC;
        end else begin
            mem_region_ff <= RG_OTHER;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_byte_half_keep: assert property (
        (wr_en && wr_sel == SEL_D0_LO && !alu_flag_en) |=>
        cur[0][15:8] == $past(cur[0][15:8]) && cur[0][7:0] == $past(wd[7:0]))
        else $error("byte write disturbed other half");
    a_pair_low_split: assert property (
        (wr_en && wr_sel == SEL_PAIR_LO && !alu_flag_en) |=>
        {cur[2], cur[0]} == $past(wd))
        else $error("data pair write wrong");
    a_addr_pair_split: assert property (
        (wr_en && wr_sel == SEL_A_PAIR && !alu_flag_en) |=>
        rd_val(SEL_A_PAIR) == $past(wd))
        else $error("address pair write wrong");
    a_pc_advance: assert property (
        (pc_adv_en && !(wr_en && wr_sel == SEL_PC)) |=>
        program_counter_ff == $past(program_counter_ff) + 20'($past(pc_adv_len)))
        else $error("pc advance wrong");
    a_sp_select: assert property (
        (eu_rd_sel == SEL_SP) |=> eu_rd_data[15:0] ==
        ($past(cpu_flags_ff[FLG_U]) ? $past(interrupt_stack_pointer_ff)
                                   : $past(user_stack_pointer_ff)))
        else $error("active stack pointer wrong");
    a_zero_sign_flag: assert property (
        alu_flag_en |=>
        cpu_flags_ff[FLG_Z] == (($past(alu_size) == SZ_BYTE) ? ($past(alu_result[7:0]) == 8'h00) :
                                ($past(alu_size) == SZ_WORD) ? ($past(alu_result[15:0]) == 16'h0000) :
                                ($past(alu_result) == 32'h0000_0000))
        && cpu_flags_ff[FLG_S] == (($past(alu_size) == SZ_BYTE) ? $past(alu_result[7]) :
                                   ($past(alu_size) == SZ_WORD) ? $past(alu_result[15]) : $past(alu_result[31])))
        else $error("zero or sign flag wrong");
    a_carry_ovf_flag: assert property (
        alu_flag_en |=> cpu_flags_ff[FLG_C] == $past(alu_carry)
        && cpu_flags_ff[FLG_O] == $past(alu_overflow))
        else $error("carry or overflow flag wrong");
    a_bank_isolate: assert property (
        (wr_en && wr_sel == SEL_DATA0 && !bk) |=> $stable(bank_ff[1][0]))
        else $error("inactive bank written");
    a_region_decode: assert property (
        1'b1 |=> ($past(mem_addr) != VEC_BASE || mem_region == RG_VEC)
        && ($past(mem_addr) != RAM_BASE || mem_region == RG_RAM)
        && ($past(mem_addr) != SFR1_BASE || mem_region == RG_SFR))
        else $error("region decode wrong");
    a_apb_answer: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    // Load checks compare against the value written one edge earlier
    a_byte_hi_keep: assert property (
        (wr_en && wr_sel == SEL_D1_HI) |=>
        cur[1][7:0] == $past(cur[1][7:0]) && cur[1][15:8] == $past(wd[7:0]))
        else $error("upper byte write disturbed lower half");
    a_pair_high_split: assert property (
        (wr_en && wr_sel == SEL_PAIR_HI) |=>
        {cur[3], cur[1]} == $past(wd))
        else $error("high data pair write wrong");
    a_flag_store: assert property (
        (wr_en && wr_sel == SEL_FLG && !alu_flag_en) |=>
        cpu_flags_ff == $past(wd[FLG_W-1:0]))
        else $error("flag register write wrong");
    a_vector_table_base_load: assert property (
        (wr_en && wr_sel == SEL_VECTOR_TABLE_BASE) |=>
        vector_table_base_out == $past(wd[19:0]))
        else $error("vector table base write wrong");
    a_sb_load: assert property (
        (wr_en && wr_sel == SEL_SB) |=>
        static_base_ff == $past(wd[15:0]))
        else $error("static base write wrong");

    c_pair_write: cover property (wr_en && wr_sel == SEL_PAIR_HI);
    c_bank1_write: cover property (bk && wr_en && wr_sel == SEL_DATA3);
    c_flag_update: cover property (alu_flag_en && alu_size == SZ_BYTE);
    c_apb_error: cover property (pready && pslverr);

endmodule

/* File: dv/eu_model.sv */
// Execution unit and ALU model on the far side of the register set
`timescale 1ns/1ps
module eu_model
    import core_regs_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic [31:0]      eu_rd_data,
    input  wire logic [2:0]       mem_region,
    output logic                  eu_wr_en,
    output logic      [SEL_W-1:0] eu_wr_sel,
    output logic      [31:0]      eu_wr_data,
    output logic      [SEL_W-1:0] eu_rd_sel,
    output logic                  alu_flag_en,
    output logic      [1:0]       alu_size,
    output logic      [31:0]      alu_result,
    output logic                  alu_carry,
    output logic                  alu_overflow,
    output logic                  pc_adv_en,
    output logic      [3:0]       pc_adv_len,
    output logic      [19:0]      mem_addr
);
    initial begin
        {eu_wr_en, alu_flag_en, pc_adv_en, alu_carry, alu_overflow} = 5'h00;
        {eu_wr_sel, eu_rd_sel, alu_size, pc_adv_len} = 16'h0000;
        {eu_wr_data, alu_result} = 64'h0;
        mem_addr = 20'h00000;
    end
    task automatic wr(input logic [SEL_W-1:0] s, input logic [31:0] d);
        @(posedge pclk);
        eu_wr_en <= 1'b1;
        eu_wr_sel <= s;
        eu_wr_data <= (s == SEL_FLG) ? (d & ~(32'h1 << FLG_D)) : d;
        @(posedge pclk);
        eu_wr_en <= 1'b0;
        // Released bus shows junk, so stale data cannot pass
        eu_wr_data <= ~d;
    endtask
    task automatic rd(input logic [SEL_W-1:0] s, output logic [31:0] d);
        @(posedge pclk);
        eu_rd_sel <= s;
        @(posedge pclk);
        #1 d = eu_rd_data;
    endtask
    task automatic alu(input logic [1:0] sz, input logic [31:0] r, input logic c, input logic o);
        @(posedge pclk);
        alu_flag_en <= 1'b1;
        alu_size <= sz;
        alu_result <= r;
        alu_carry <= c;
        alu_overflow <= o;
        @(posedge pclk);
        alu_flag_en <= 1'b0;
        alu_result <= ~r;
        #1;
    endtask
    task automatic adv(input logic [3:0] n);
        @(posedge pclk);
        pc_adv_en <= 1'b1;
        pc_adv_len <= n;
        @(posedge pclk);
        pc_adv_en <= 1'b0;
        #1;
    endtask
    task automatic region(input logic [19:0] a, output logic [2:0] r);
        @(posedge pclk);
        mem_addr <= a;
        @(posedge pclk);
        #1 r = mem_region;
    endtask
endmodule

/* File: dv/cpu_core_register_set_tb_top.sv */
// Self-checking testbench for the core register set
`timescale 1ns/1ps
module cpu_core_register_set_tb_top;
    import core_regs_pkg::*;
    localparam logic [19:0] RAM_TOP = 20'h011FF;
    localparam logic [19:0] DFL_TOP = 20'h037FF;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic             eu_wr_en, alu_flag_en, alu_carry, alu_overflow, pc_adv_en;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, eu_rd_data, eu_wr_data, alu_result;
    logic [SEL_W-1:0] eu_wr_sel, eu_rd_sel;
    logic [1:0]       alu_size;
    logic [3:0]       pc_adv_len;
    logic [19:0]      mem_addr, pc_out, vector_table_base_out;
    logic [2:0]       mem_region;
    logic [FLG_W-1:0] flags_out;
    int               errors, checks_done;

    core_regs #(.APB_AW(8), .RAM_END(RAM_TOP), .DFL_END(DFL_TOP)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eu_wr_en(eu_wr_en), .eu_wr_sel(eu_wr_sel), .eu_wr_data(eu_wr_data), .eu_rd_sel(eu_rd_sel),
        .eu_rd_data(eu_rd_data), .alu_flag_en(alu_flag_en), .alu_size(alu_size), .alu_result(alu_result),
        .alu_carry(alu_carry), .alu_overflow(alu_overflow), .pc_adv_en(pc_adv_en), .pc_adv_len(pc_adv_len),
        .mem_addr(mem_addr), .mem_region(mem_region), .pc_out(pc_out), .vector_table_base_out(vector_table_base_out),
        .flags_out(flags_out));
    eu_model eu (
        .pclk(pclk), .eu_rd_data(eu_rd_data), .mem_region(mem_region), .eu_wr_en(eu_wr_en),
        .eu_wr_sel(eu_wr_sel), .eu_wr_data(eu_wr_data), .eu_rd_sel(eu_rd_sel), .alu_flag_en(alu_flag_en),
        .alu_size(alu_size), .alu_result(alu_result), .alu_carry(alu_carry), .alu_overflow(alu_overflow),
        .pc_adv_en(pc_adv_en), .pc_adv_len(pc_adv_len), .mem_addr(mem_addr));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
        end
    endtask
    // No count of its own on pready; only the watchdog ends a stuck wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic bwr(input logic [4:0] c, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, {1'b0, c, 2'b00}, d, r, e);
    endtask
    task automatic brd(input logic [4:0] c, input logic [31:0] x, input string m);
        logic [31:0] r;
        logic e;
        apb(1'b0, {1'b0, c, 2'b00}, 32'h0, r, e);
        chk(r, x, m);
    endtask
    task automatic fl(input logic [1:0] sz, input logic [31:0] v, input logic c, input logic o,
                      input logic [3:0] x);
        eu.alu(sz, v, c, o);
        chk(32'({flags_out[FLG_O], flags_out[FLG_S], flags_out[FLG_Z], flags_out[FLG_C]}), 32'(x), "alu flags");
    endtask

    task automatic t_full();
        logic [4:0] c;
        logic [31:0] m;
        for (int i = 0; i < 12; i++) begin
            c = (i < 7) ? 5'(i) : 5'(i + 8);
            m = (c == SEL_VECTOR_TABLE_BASE || c == SEL_PC) ? 32'h000F_FFFF : 32'h0000_FFFF;
            bwr(c, 32'hA5C3_5A3C ^ 32'(c));
            brd(c, (32'hA5C3_5A3C ^ 32'(c)) & m, "full reg");
        end
        chk(32'(vector_table_base_out), 32'h0003_5A2C, "vector_table_base port");
        chk(32'(pc_out), 32'h0003_5A2D, "pc port");
    endtask
    task automatic t_bytes();
        logic [31:0] r;
        bwr(SEL_DATA0, 32'h0000_1234);
        bwr(SEL_D0_LO, 32'hFFFF_FFAB);
        bwr(5'h09, 32'h0000_00CD);
        brd(SEL_DATA0, 32'h0000_CDAB, "data0 bytes");
        brd(SEL_D0_LO, 32'h0000_00AB, "data0 low");
        eu.wr(5'h01, 32'h0000_5678);
        eu.wr(5'h0A, 32'h0000_0011);
        eu.wr(SEL_D1_HI, 32'h0000_0022);
        eu.rd(5'h01, r);
        chk(r, 32'h0000_2211, "data1 bytes");
    endtask
    task automatic t_pairs();
        logic [31:0] d, r;
        logic [4:0] lo;
        for (int i = 0; i < 3; i++) begin
            d = 32'h89AB_CDEF + 32'(i * 32'h0101_0101);
            lo = (i == 2) ? 5'h04 : 5'(i);
            eu.wr(SEL_PAIR_LO + 5'(i), d);
            brd(lo, {16'h0, d[15:0]}, "pair low half");
            brd(lo + ((i == 2) ? 5'h1 : 5'h2), {16'h0, d[31:16]}, "pair high half");
            eu.rd(SEL_PAIR_LO + 5'(i), r);
            chk(r, d, "pair read");
        end
    endtask
    task automatic t_flags();
        fl(SZ_BYTE, 32'h0000_0100, 1'b1, 1'b0, 4'b0011);
        fl(SZ_BYTE, 32'h0000_0080, 1'b0, 1'b1, 4'b1100);
        fl(SZ_WORD, 32'h0001_0000, 1'b0, 1'b0, 4'b0010);
        fl(SZ_WORD, 32'h0000_8000, 1'b1, 1'b0, 4'b0101);
        fl(2'h2, 32'h8000_0000, 1'b0, 1'b1, 4'b1100);
        fl(2'h3, 32'h0000_0000, 1'b0, 1'b0, 4'b0010);
        brd(SEL_FLG, 32'h0000_0004, "flags read");
    endtask
    task automatic t_bank();
        logic [31:0] r;
        bwr(SEL_DATA0, 32'h0000_1111);
        bwr(SEL_FLG, 32'h0000_0010);
        brd(SEL_DATA0, 32'h0, "bank1 data0");
        bwr(SEL_DATA0, 32'h0000_2222);
        bwr(SEL_FLG, 32'h0);
        brd(SEL_DATA0, 32'h0000_1111, "bank0 data0");
        bwr(SEL_USP, 32'h0000_0AAA);
        bwr(SEL_ISP, 32'h0000_0BBB);
        brd(SEL_SP, 32'h0000_0AAA, "user sp");
        bwr(SEL_FLG, 32'h0000_0080);
        brd(SEL_SP, 32'h0000_0BBB, "int sp");
        eu.rd(SEL_SP, r);
        chk(r, 32'h0000_0BBB, "eu active sp");
        bwr(SEL_FLG, 32'hFFFF_FFED);
        brd(SEL_FLG, 32'h0000_07ED, "flags width");
        bwr(SEL_FLG, 32'h0);
    endtask
    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'h1C, 32'h0000_FFFF, r, e);
        chk(32'(e), 32'h1, "slverr write");
        apb(1'b0, 8'h58, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "slverr read");
        apb(1'b1, 8'h80, 32'h0000_9999, r, e);
        chk(32'(e), 32'h1, "slverr high");
        brd(SEL_DATA0, 32'h0000_1111, "data0 intact");
    endtask
    task automatic t_region();
        logic [19:0] a [15] = '{20'h00000, 20'h002FF, 20'h00300, 20'h00400, RAM_TOP, RAM_TOP + 20'h1,
            20'h02C00, 20'h02FFF, 20'h03000, DFL_TOP, DFL_TOP + 20'h1, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF,
            20'hFFFFF};
        logic [2:0] x [15] = '{RG_SFR, RG_SFR, RG_OTHER, RG_RAM, RG_RAM, RG_OTHER, RG_SFR, RG_SFR,
            RG_DFL, RG_DFL, RG_OTHER, RG_OTHER, RG_VEC, RG_VEC, RG_OTHER};
        logic [2:0] r;
        for (int i = 0; i < 15; i++) begin
            eu.region(a[i], r);
            chk(32'(r), 32'(x[i]), "region");
        end
    endtask

    initial begin
        errors = 0;
        checks_done = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(pc_out), 32'(RST_PC), "pc reset");
        chk(32'(flags_out), 32'(RST_FLG), "flags reset");
        brd(SEL_DATA0, 32'(RST_WORD), "data0 reset");
        t_full();
        t_bytes();
        t_pairs();
        t_flags();
        t_bank();
        t_unmapped();
        bwr(SEL_PC, 32'h000F_FFFE);
        eu.adv(4'h3);
        chk(32'(pc_out), 32'h0000_0001, "pc wrap");
        t_region();
        give_verdict();
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end
endmodule
